//--- design/proc_ctrl_pkg.sv
// constants and types shared by the processor control block and its alu
// assumes a single 50 MHz clock
package proc_ctrl_pkg;

  // clock and initialize timing
  localparam int CLOCK_MHZ     = 50;
  localparam int INIT_TIME_NS  = 10000;  // bus initialize pulse after dc power good
  localparam int INIT_CYCLES   = (INIT_TIME_NS * CLOCK_MHZ + 999) / 1000;
  localparam int INIT_CNT_W    = 10;

  // status word layout
  localparam int SW_W          = 8;
  localparam int SW_PRIO_BIT   = 7;  // external interrupt enable
  localparam int SW_TRACE_BIT  = 4;  // trace trap enable
  localparam int SW_N_BIT      = 3;
  localparam int SW_Z_BIT      = 2;
  localparam int SW_V_BIT      = 1;
  localparam int SW_C_BIT      = 0;
  localparam logic [7:0] SW_RESET    = 8'h00;
  localparam logic [7:0] SW_RSV_MASK = 8'h60;  // bits 6:5 read as zero

  // general registers
  localparam int WORD_W        = 16;
  localparam int BYTE_W        = 8;
  localparam int NUM_REGS      = 8;
  localparam logic [2:0] LAST_BYTE_REG = 3'h5;
  localparam logic [2:0] SP_INDEX      = 3'h6;
  localparam logic [2:0] PC_INDEX      = 3'h7;
  localparam logic [15:0] REG_RESET    = 16'h0000;

  // power fail trap vector, 24 octal
  localparam logic [15:0] POWER_FAIL_VECTOR = 16'h0014;

  // jumper selected power-up behaviour
  typedef enum logic [1:0] {
    PUP_VECTOR  = 2'h0,
    PUP_CONSOLE = 2'h1,
    PUP_BOOT    = 2'h2,
    PUP_USER    = 2'h3
  } powerup_mode_t;

  // alu operations
  typedef enum logic [3:0] {
    OP_MOV = 4'h0,
    OP_ADD = 4'h1,
    OP_SUB = 4'h2,
    OP_AND = 4'h3,
    OP_OR  = 4'h4,
    OP_XOR = 4'h5,
    OP_COM = 4'h6,
    OP_NEG = 4'h7,
    OP_INC = 4'h8,
    OP_DEC = 4'h9,
    OP_ASR = 4'ha,
    OP_ASL = 4'hb
  } alu_op_t;

  // overall control states, one-hot
  typedef enum logic [5:0] {
    ST_RESET = 6'h01,
    ST_INIT  = 6'h02,
    ST_PWAIT = 6'h04,
    ST_RUN   = 6'h08,
    ST_HALT  = 6'h10,
    ST_STEP  = 6'h20
  } ctrl_state_t;

endpackage : proc_ctrl_pkg

//--- design/alu_if.sv
// operands, result and flags between the control block and its alu
// assumes one clock domain; all signals combinational
`timescale 1ns/1ps
interface alu_if;
  proc_ctrl_pkg::alu_op_t op;
  logic                   byte_op;
  logic [15:0]            a;
  logic [15:0]            b;
  logic [15:0]            result;
  logic [3:0]             flags;   // n z v c
  logic [3:0]             update;  // which flags the operation touches

  modport ctrl (output op, byte_op, a, b, input result, flags, update);
  modport alu  (input op, byte_op, a, b, output result, flags, update);
endinterface : alu_if

//--- design/proc_alu.sv
// combinational two's complement alu for byte and word operands
// assumes the caller registers result and flags
`timescale 1ns/1ps
module proc_alu (
  alu_if.alu bus
);

  // sign of a value at the chosen operand width
  function automatic logic msb_of(input logic [15:0] v, input logic is_byte);
    msb_of = is_byte ? v[7] : v[15];
  endfunction

  // zero test at the chosen operand width
  function automatic logic zero_of(input logic [15:0] v, input logic is_byte);
    zero_of = is_byte ? (v[7:0] == 8'h00) : (v == 16'h0000);
  endfunction

  logic [15:0] ea;
  logic [15:0] eb;
  logic [16:0] wide;
  logic [15:0] r;
  logic        carry;
  logic        sa;
  logic        sb;
  logic        sr;

  //////////////////////////////////////////////////////////////////////////////
  // twos complement arithmetic
  always_comb begin
    ea    = bus.byte_op ? {8'h00, bus.a[7:0]} : bus.a;
    eb    = bus.byte_op ? {8'h00, bus.b[7:0]} : bus.b;
    unique case (bus.op)
      proc_ctrl_pkg::OP_ADD: wide = {1'b0, ea} + {1'b0, eb};
      proc_ctrl_pkg::OP_SUB: wide = {1'b0, ea} - {1'b0, eb};
      proc_ctrl_pkg::OP_NEG: wide = 17'h00000 - {1'b0, ea};
      proc_ctrl_pkg::OP_INC: wide = {1'b0, ea} + 17'h00001;
      proc_ctrl_pkg::OP_DEC: wide = {1'b0, ea} - 17'h00001;
      default:               wide = {1'b0, ea};
    endcase
    carry = bus.byte_op ? wide[8] : wide[16];
    unique case (bus.op)
      proc_ctrl_pkg::OP_MOV: r = ea;
      proc_ctrl_pkg::OP_AND: r = ea & eb;
      proc_ctrl_pkg::OP_OR:  r = ea | eb;
      proc_ctrl_pkg::OP_XOR: r = ea ^ eb;
      proc_ctrl_pkg::OP_COM: r = ~ea;
      proc_ctrl_pkg::OP_ASR: r = bus.byte_op ? {8'h00, ea[7], ea[7:1]} : {ea[15], ea[15:1]};
      proc_ctrl_pkg::OP_ASL: r = {ea[14:0], 1'b0};
      default:               r = wide[15:0];
    endcase
    if (bus.byte_op) begin
      r = {8'h00, r[7:0]};
    end
  end

  assign sa = msb_of(ea, bus.byte_op);
  assign sb = msb_of(eb, bus.byte_op);
  assign sr = msb_of(r, bus.byte_op);
  assign bus.result = r;

  always_comb begin
    bus.flags = {sr, zero_of(r, bus.byte_op), 1'b0, 1'b0};
    unique case (bus.op)
      proc_ctrl_pkg::OP_ADD: bus.flags[1:0] = {(sa == sb) && (sr != sa), carry};
      proc_ctrl_pkg::OP_SUB: bus.flags[1:0] = {(sa != sb) && (sr != sa), carry};
      proc_ctrl_pkg::OP_NEG: bus.flags[1:0] = {sr && zero_of({r[14:0], 1'b0}, bus.byte_op)
                                               && (bus.byte_op ? (r[6:0] == 7'h00) : 1'b1),
                                               !zero_of(r, bus.byte_op)};
      proc_ctrl_pkg::OP_INC: bus.flags[1:0] = {sr && !sa, 1'b0};
      proc_ctrl_pkg::OP_DEC: bus.flags[1:0] = {!sr && sa, 1'b0};
      proc_ctrl_pkg::OP_COM: bus.flags[1:0] = 2'h1;
      proc_ctrl_pkg::OP_ASR: bus.flags[1:0] = {sr ^ ea[0], ea[0]};
      proc_ctrl_pkg::OP_ASL: bus.flags[1:0] = {sr ^ sa, sa};
      default:               bus.flags[1:0] = 2'h0;
    endcase
  end

  // carry is left alone by moves, and/or/xor and inc/dec
  always_comb begin
    unique case (bus.op)
      proc_ctrl_pkg::OP_MOV, proc_ctrl_pkg::OP_AND, proc_ctrl_pkg::OP_OR,
      proc_ctrl_pkg::OP_XOR, proc_ctrl_pkg::OP_INC, proc_ctrl_pkg::OP_DEC:
        bus.update = 4'he;
      default:
        bus.update = 4'hf;
    endcase
  end

endmodule : proc_alu

//--- design/proc_power_run_halt.sv
// overall processor control: power sequencing, run/halt, status word, general registers
// assumes power pins, halt switch and jumper are asynchronous; console and execution
// strobes come from logic on i_clock
`timescale 1ns/1ps
module proc_power_run_halt (
  input  wire logic        i_clock,
  input  wire logic        i_reset_n,
  input  wire logic        i_dc_power_good,
  input  wire logic        i_ac_power_good,
  input  wire logic        i_halt_switch,
  input  wire logic [1:0]  i_powerup_jumper,
  input  wire logic        i_resume,
  input  wire logic        i_restart,
  input  wire logic [15:0] i_restart_addr,
  input  wire logic        i_step_done,
  input  wire logic        i_alu_valid,
  input  wire logic [3:0]  i_alu_op,
  input  wire logic        i_alu_byte,
  input  wire logic [15:0] i_alu_a,
  input  wire logic [15:0] i_alu_b,
  input  wire logic        i_reg_wr,
  input  wire logic [2:0]  i_reg_wr_addr,
  input  wire logic        i_reg_wr_byte,
  input  wire logic [15:0] i_reg_wr_data,
  input  wire logic [2:0]  i_reg_rd_addr,
  input  wire logic        i_reg_rd_byte,
  input  wire logic        i_read_status_instr,
  input  wire logic        i_write_status_instr,
  input  wire logic [7:0]  i_write_status_data,
  input  wire logic        i_console_status_wr,
  input  wire logic [7:0]  i_console_status_data,
  output logic             o_bus_init_n,
  output logic             o_running,
  output logic             o_halted,
  output logic             o_halt_irq,
  output logic             o_powerup_start,
  output logic [1:0]       o_powerup_mode,
  output logic             o_power_fail_trap,
  output logic [15:0]      o_trap_vector,
  output logic [15:0]      o_alu_result,
  output logic [15:0]      o_reg_rd_data,
  output logic [15:0]      o_stack_pointer,
  output logic [15:0]      o_program_counter,
  output logic [7:0]       o_status_word
);

  alu_if alu_bus ();

  proc_alu u_alu (
    .bus (alu_bus)
  );

  // register index that allows byte access
  function automatic logic byte_ok(input logic [2:0] idx);
    byte_ok = (idx <= proc_ctrl_pkg::LAST_BYTE_REG);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // two-flop synchronisers for every pin input
  logic [4:0] sync_meta;
  logic [4:0] sync_pins;
  logic       dc_good;
  logic       ac_good;
  logic       halt_req;
  logic [1:0] jumper;
  logic       ac_good_last;

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sync_meta <= 5'h00;
      sync_pins <= 5'h00;
    end else begin
      sync_meta <= {i_powerup_jumper, i_halt_switch, i_ac_power_good, i_dc_power_good};
      sync_pins <= sync_meta;
    end
  end

  assign dc_good  = sync_pins[0];
  assign ac_good  = sync_pins[1];
  assign halt_req = sync_pins[2];
  assign jumper   = sync_pins[4:3];

  // previous ac level for the falling edge
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ac_good_last <= 1'b0;
    end else begin
      ac_good_last <= ac_good;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // overall control state machine
  proc_ctrl_pkg::ctrl_state_t state;
  proc_ctrl_pkg::ctrl_state_t next_state;
  logic [proc_ctrl_pkg::INIT_CNT_W-1:0] init_cnt;
  logic       init_done;
  logic       ac_drop;
  logic       console_mode;

  assign init_done    = (init_cnt == proc_ctrl_pkg::INIT_CNT_W'(proc_ctrl_pkg::INIT_CYCLES - 1));
  assign ac_drop      = ac_good_last && !ac_good;
  assign console_mode = (o_powerup_mode == proc_ctrl_pkg::PUP_CONSOLE);

  always_comb begin
    next_state = state;
    unique case (state)
      proc_ctrl_pkg::ST_RESET: begin
        if (dc_good) begin
          next_state = proc_ctrl_pkg::ST_INIT;
        end
      end
      proc_ctrl_pkg::ST_INIT: begin
        if (init_done) begin
          next_state = proc_ctrl_pkg::ST_PWAIT;
        end
      end
      proc_ctrl_pkg::ST_PWAIT: begin
        if (ac_good) begin
          next_state = console_mode ? proc_ctrl_pkg::ST_HALT : proc_ctrl_pkg::ST_RUN;
        end
      end
      proc_ctrl_pkg::ST_RUN: begin
        if (halt_req && !ac_drop) begin
          next_state = proc_ctrl_pkg::ST_HALT;
        end
      end
      proc_ctrl_pkg::ST_HALT: begin
        if (i_restart) begin
          next_state = proc_ctrl_pkg::ST_RUN;
        end else if (i_resume) begin
          next_state = halt_req ? proc_ctrl_pkg::ST_STEP : proc_ctrl_pkg::ST_RUN;
        end
      end
      proc_ctrl_pkg::ST_STEP: begin
        if (i_step_done) begin
          next_state = halt_req ? proc_ctrl_pkg::ST_HALT : proc_ctrl_pkg::ST_RUN;
        end
      end
    endcase
    if (!dc_good) begin
      next_state = proc_ctrl_pkg::ST_RESET;
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state <= proc_ctrl_pkg::ST_RESET;
    end else begin
      state <= next_state;
    end
  end

  // initialize length counter, cleared outside init
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      init_cnt <= '0;
    end else if (state != proc_ctrl_pkg::ST_INIT) begin
      init_cnt <= '0;
    end else if (!init_done) begin
      init_cnt <= init_cnt + 1'b1;
    end
  end

  // jumper caught as dc good returns
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_powerup_mode <= proc_ctrl_pkg::PUP_VECTOR;
    end else if (state == proc_ctrl_pkg::ST_RESET && dc_good) begin
      o_powerup_mode <= jumper;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // registered control outputs, glitch free
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_bus_init_n      <= 1'b0;
      o_running         <= 1'b0;
      o_halted          <= 1'b0;
      o_halt_irq        <= 1'b0;
      o_powerup_start   <= 1'b0;
      o_power_fail_trap <= 1'b0;
    end else begin
      o_bus_init_n      <= (next_state != proc_ctrl_pkg::ST_RESET)
                           && (next_state != proc_ctrl_pkg::ST_INIT);
      o_running         <= (next_state == proc_ctrl_pkg::ST_RUN)
                           || (next_state == proc_ctrl_pkg::ST_STEP);
      o_halted          <= (next_state == proc_ctrl_pkg::ST_HALT);
      o_halt_irq        <= (state == proc_ctrl_pkg::ST_RUN)
                           && (next_state == proc_ctrl_pkg::ST_HALT);
      o_powerup_start   <= (state == proc_ctrl_pkg::ST_PWAIT) && (next_state != state);
      // trap on ac drop in run
      o_power_fail_trap <= (state == proc_ctrl_pkg::ST_RUN) && dc_good && ac_drop;
    end
  end

  assign o_trap_vector = proc_ctrl_pkg::POWER_FAIL_VECTOR;

  //////////////////////////////////////////////////////////////////////////////
  // alu drive and registered result
  assign alu_bus.op      = proc_ctrl_pkg::alu_op_t'(i_alu_op);
  assign alu_bus.byte_op = i_alu_byte;
  assign alu_bus.a       = i_alu_a;
  assign alu_bus.b       = i_alu_b;

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_alu_result <= proc_ctrl_pkg::REG_RESET;
    end else if (i_alu_valid) begin
      o_alu_result <= alu_bus.result;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // status word; priority console, write, read, alu
  logic [7:0] sw_read_flags;

  always_comb begin
    sw_read_flags = o_status_word;
    sw_read_flags[proc_ctrl_pkg::SW_N_BIT] = o_status_word[proc_ctrl_pkg::SW_PRIO_BIT];
    sw_read_flags[proc_ctrl_pkg::SW_Z_BIT] = (o_status_word == 8'h00);
    sw_read_flags[proc_ctrl_pkg::SW_V_BIT] = 1'b0;
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_status_word <= proc_ctrl_pkg::SW_RESET;
    end else if (!dc_good) begin
      o_status_word <= proc_ctrl_pkg::SW_RESET;
    end else if (i_console_status_wr) begin
      o_status_word <= i_console_status_data & ~proc_ctrl_pkg::SW_RSV_MASK;
    end else if (i_write_status_instr) begin
      // write instr, trace may only clear
      o_status_word <= (i_write_status_data & ~proc_ctrl_pkg::SW_RSV_MASK
                        & ~(8'h01 << proc_ctrl_pkg::SW_TRACE_BIT))
                       | (i_write_status_data & o_status_word
                          & (8'h01 << proc_ctrl_pkg::SW_TRACE_BIT));
    end else if (i_read_status_instr) begin
      // moving the status word sets n z, clears v
      o_status_word <= sw_read_flags;
    end else if (i_alu_valid) begin
      o_status_word[proc_ctrl_pkg::SW_N_BIT:proc_ctrl_pkg::SW_C_BIT] <=
        (alu_bus.flags & alu_bus.update)
        | (o_status_word[proc_ctrl_pkg::SW_N_BIT:proc_ctrl_pkg::SW_C_BIT] & ~alu_bus.update);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // general registers, internal only with no bus cycle
  logic [15:0] regs [proc_ctrl_pkg::NUM_REGS];

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      for (int k = 0; k < proc_ctrl_pkg::NUM_REGS; k++) begin
        regs[k] <= proc_ctrl_pkg::REG_RESET;
      end
    end else if (state == proc_ctrl_pkg::ST_HALT && i_restart) begin
      regs[proc_ctrl_pkg::PC_INDEX] <= i_restart_addr;
    end else if (i_reg_wr) begin
      if (i_reg_wr_byte && byte_ok(i_reg_wr_addr)) begin
        regs[i_reg_wr_addr][7:0] <= i_reg_wr_data[7:0];
      end else begin
        regs[i_reg_wr_addr] <= i_reg_wr_data;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_reg_rd_data <= proc_ctrl_pkg::REG_RESET;
    end else if (i_reg_rd_byte && byte_ok(i_reg_rd_addr)) begin
      o_reg_rd_data <= {8'h00, regs[i_reg_rd_addr][7:0]};
    end else begin
      o_reg_rd_data <= regs[i_reg_rd_addr];
    end
  end

  assign o_stack_pointer   = regs[proc_ctrl_pkg::SP_INDEX];
  assign o_program_counter = regs[proc_ctrl_pkg::PC_INDEX];

endmodule : proc_power_run_halt

//--- tb/proc_power_run_halt_assertions.sv
// concurrent checks on the ports of the processor power, run and halt control
// assumes one clock domain and an active-low asynchronous reset
`timescale 1ns/1ps
module proc_power_run_halt_assertions (
  input wire logic        i_clock,
  input wire logic        i_reset_n,
  input wire logic        i_dc_power_good,
  input wire logic        i_ac_power_good,
  input wire logic        i_halt_switch,
  input wire logic        i_resume,
  input wire logic        i_restart,
  input wire logic [15:0] i_restart_addr,
  input wire logic        i_alu_valid,
  input wire logic [3:0]  i_alu_op,
  input wire logic        i_alu_byte,
  input wire logic [15:0] i_alu_a,
  input wire logic [15:0] i_alu_b,
  input wire logic        i_read_status_instr,
  input wire logic        i_write_status_instr,
  input wire logic        i_console_status_wr,
  input wire logic        o_bus_init_n,
  input wire logic        o_running,
  input wire logic        o_halted,
  input wire logic        o_halt_irq,
  input wire logic        o_power_fail_trap,
  input wire logic [15:0] o_trap_vector,
  input wire logic [15:0] o_alu_result,
  input wire logic [15:0] o_program_counter,
  input wire logic [7:0]  o_status_word
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);

  ////////////////////////////////////////////////////////////////////////////////
  // pins pass two sync flops, so a pin change shows three edges on
  chk_dc_init_hold: assert property (!i_dc_power_good [*4] |-> !o_bus_init_n && !o_running)
    else $error("init not held");
  chk_ac_drop_trap: assert property ($fell(i_ac_power_good) && o_running && !i_halt_switch
    && i_dc_power_good ##1 (o_running && i_dc_power_good) [*2] |-> ##[0:2] o_power_fail_trap)
    else $error("no trap");
  chk_trap_vector_val: assert property (o_power_fail_trap |-> o_trap_vector == 16'h0014
    && $past(o_running)) else $error("bad trap");
  chk_halt_irq_entry: assert property (o_halt_irq |-> o_halted && !o_running
    && $past(o_running)) else $error("bad halt irq");
  chk_halt_switch_on: assert property (o_running && $rose(i_halt_switch) && i_dc_power_good
    ##1 (i_halt_switch && i_ac_power_good && i_dc_power_good) [*3] |-> ##[0:1] o_halted)
    else $error("no halt");
  chk_restart_run: assert property (o_halted && i_restart && i_dc_power_good |=> o_running
    && o_program_counter == $past(i_restart_addr)) else $error("bad restart");
  chk_single_step: assert property (o_halted && i_resume && !i_restart && i_dc_power_good
    && i_halt_switch && $past(i_halt_switch) && $past(i_halt_switch, 2) |=> o_running && !o_halted)
    else $error("no step");
  chk_add_word: assert property (i_alu_valid && i_alu_op == 4'h1 && !i_alu_byte
    |=> o_alu_result == $past(i_alu_a) + $past(i_alu_b)) else $error("bad add");
  chk_and_byte: assert property (i_alu_valid && i_alu_op == 4'h3 && i_alu_byte |=>
    o_alu_result == {8'h00, $past(i_alu_a[7:0]) & $past(i_alu_b[7:0])}) else $error("bad and");
  chk_zero_flag: assert property (i_alu_valid && i_alu_op == 4'h5 && i_alu_a == i_alu_b
    && !i_console_status_wr && !i_write_status_instr && !i_read_status_instr && i_dc_power_good
    |=> o_status_word[3:1] == 3'h2) else $error("bad z flag");
  chk_rsv_zero: assert property (o_status_word[6:5] == 2'h0)
    else $error("rsv bits set");
  chk_trace_clear_only: assert property (i_write_status_instr && !i_console_status_wr
    && i_dc_power_good && !o_status_word[4] |=> !o_status_word[4]) else $error("trace set");
endmodule // proc_power_run_halt_assertions

bind proc_power_run_halt proc_power_run_halt_assertions u_proc_power_run_halt_assertions (.*);

//--- tb/supply_model.sv
// power supply status model: dc good up first, ac good later;
// ac good falls first on power-down; assumes one clock
`timescale 1ns/1ps
module supply_model #(
  parameter int DELAY = 600
) (
  input  wire logic i_clock,
  input  wire logic i_power_on,
  output logic      o_dc_power_good = 1'b0,
  output logic      o_ac_power_good = 1'b0
);
  logic [11:0] count = 12'h000;

  // ac last up and first down, so dc never drops under a good ac
  always @(posedge i_clock) begin
    count <= count + 12'h001;
    if (i_power_on && !o_dc_power_good) begin
      o_dc_power_good <= 1'b1;
      count <= 12'h000;
    end else if (!i_power_on && o_ac_power_good) begin
      o_ac_power_good <= 1'b0;
      count <= 12'h000;
    end else if (count == DELAY) begin
      o_ac_power_good <= i_power_on;
      o_dc_power_good <= i_power_on;
    end
  end
endmodule // supply_model

//--- tb/testbench.sv
// self-checking bench for the power, run and halt control
// assumes the supply model and the bound checker
`timescale 1ns/1ps
module testbench;
  logic        i_clock = 1'b0, i_reset_n = 1'b0, i_halt_switch = 1'b0, power_on = 1'b0;
  logic        i_resume = 1'b0, i_restart = 1'b0, i_step_done = 1'b0, i_alu_valid = 1'b0;
  logic        i_alu_byte = 1'b0, i_reg_wr = 1'b0, i_reg_wr_byte = 1'b0, i_reg_rd_byte = 1'b0;
  logic        i_read_status_instr = 1'b0, i_write_status_instr = 1'b0, i_console_status_wr = 1'b0;
  logic [1:0]  i_powerup_jumper = 2'h2;
  logic [3:0]  i_alu_op = 4'h0;
  logic [2:0]  i_reg_wr_addr = 3'h0, i_reg_rd_addr = 3'h0;
  logic [7:0]  i_write_status_data = 8'h00, i_console_status_data = 8'h00, sw = 8'h00, ctl;
  logic [15:0] i_restart_addr = 16'h0000, i_alu_a = 16'h0000, i_alu_b = 16'h0000, r, init_len;
  logic [15:0] i_reg_wr_data = 16'h0000, regs [8], o_trap_vector, o_alu_result, o_reg_rd_data;
  logic [15:0] o_stack_pointer, o_program_counter;
  logic [31:0] seed = 32'h2cdf2699;
  logic [19:0] q [$], nt;
  logic [1:0]  o_powerup_mode;
  logic        o_bus_init_n, o_running, o_halted, o_halt_irq, o_powerup_start;
  logic        o_power_fail_trap, i_dc_power_good, i_ac_power_good;
  logic [7:0]  o_status_word;
  int          check_count = 0, bad_count = 0, wait_n;

  proc_power_run_halt u_proc_power_run_halt (.*);
  supply_model #(.DELAY(600)) u_supply_model (.i_clock, .i_power_on(power_on),
    .o_dc_power_good(i_dc_power_good), .o_ac_power_good(i_ac_power_good));

  always #10 i_clock = ~i_clock;
  assign ctl = {o_bus_init_n, o_running, o_halted, o_halt_irq, o_powerup_start,
                o_power_fail_trap, o_powerup_mode};

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction

  // selector 8: run and halt bits only
  function automatic logic [15:0] pick(input logic [3:0] s);
    case (s)
      4'h0: return o_alu_result;
      4'h1: return {8'h00, o_status_word};
      4'h2: return o_reg_rd_data;
      4'h3: return o_stack_pointer;
      4'h4: return o_program_counter;
      4'h5: return o_trap_vector;
      4'h6: return {8'h00, ctl};
      4'h7: return init_len;
      default: return {14'h0000, o_running, o_halted};
    endcase
  endfunction

  // reference alu: {n z v c, result}
  function automatic logic [19:0] alu_m(input logic [3:0] op, input logic bw,
                                        input logic [15:0] a, b, input logic c);
    logic [16:0] s;
    logic [15:0] x;
    logic        sa, sb, n, v;
    a = bw ? {8'h00, a[7:0]} : a;
    b = bw ? {8'h00, b[7:0]} : b;
    case (op)
      4'h1: s = a + b;
      4'h2: s = a - b;
      4'h3: s = {1'b0, a & b};
      4'h4: s = {1'b0, a | b};
      default: s = {1'b0, a ^ b};
    endcase
    x = bw ? {8'h00, s[7:0]} : s[15:0];
    sa = bw ? a[7] : a[15];
    sb = bw ? b[7] : b[15];
    n = bw ? x[7] : x[15];
    v = (op == 4'h1) ? (sa == sb && n != sa) : (op == 4'h2) ? (sa != sb && n != sa) : 1'b0;
    if (op == 4'h1)
      c = bw ? s[8] : s[16];
    if (op == 4'h2)
      c = s[16];
    return {n, x == 16'h0000, v, c, x};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask

  task automatic note(input logic [3:0] s, input logic [15:0] exp);
    q.push_back({s, exp});
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // polls a ctl bit at falling edges; run-out is a mismatch
  task automatic wait_ctl(input int b, input logic v);
    wait_n = 0;
    while (ctl[b] !== v) begin
      @(negedge i_clock);
      wait_n++;
      if (wait_n > 2000) begin
        bad_count++;
        $display("BAD %0t wait ran out", $time);
        end_of_test();
      end
    end
  endtask

  task automatic alu(input logic [3:0] op, input logic bw, input logic [15:0] a, b);
    logic [19:0] m;
    @(posedge i_clock);
    i_alu_valid <= 1'b1;
    i_alu_op <= op;
    i_alu_byte <= bw;
    i_alu_a <= a;
    i_alu_b <= b;
    m = alu_m(op, bw, a, b, sw[0]);
    sw = {sw[7:4], m[19:16]};
    @(posedge i_clock);
    i_alu_valid <= 1'b0;
    note(4'h0, m[15:0]);
    note(4'h1, {8'h00, sw});
  endtask

  // k: 0 console, 1 write instr, 2 read instr
  task automatic stat(input int k, input logic [7:0] d);
    @(posedge i_clock);
    i_console_status_wr <= (k == 0);
    i_write_status_instr <= (k == 1);
    i_read_status_instr <= (k == 2);
    i_console_status_data <= d;
    i_write_status_data <= d;
    case (k)
      0: sw = {d[7], 2'h0, d[4:0]};
      1: sw = {d[7], 2'h0, d[4] & sw[4], d[3:0]};
      default: sw = {sw[7:4], sw[7], sw == 8'h00, 1'b0, sw[0]};
    endcase
    @(posedge i_clock);
    {i_console_status_wr, i_write_status_instr, i_read_status_instr} <= 3'h0;
    note(4'h1, {8'h00, sw});
  endtask

  // write a register, read it back
  task automatic reg_op(input logic [2:0] a, input logic bw, input logic [15:0] d, input logic rb);
    @(posedge i_clock);
    i_reg_wr <= 1'b1;
    i_reg_wr_addr <= a;
    i_reg_wr_byte <= bw;
    i_reg_wr_data <= d;
    if (bw && a <= 3'h5)
      regs[a][7:0] = d[7:0];
    else
      regs[a] = d;
    @(posedge i_clock);
    i_reg_wr <= 1'b0;
    i_reg_rd_addr <= a;
    i_reg_rd_byte <= rb;
    @(posedge i_clock);
    note(4'h2, rb ? {8'h00, regs[a][7:0]} : regs[a]);
  endtask

  // monitor: 1 ns past each falling edge, after that edge's notes
  always begin
    @(negedge i_clock);
    #1;
    while (q.size() > 0) begin
      nt = q.pop_front();
      check(pick(nt[19:16]), nt[15:0]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge i_clock);
    i_reset_n <= 1'b1;
    @(negedge i_clock);
    note(4'h6, 16'h0000);
    note(4'h5, 16'h0014);
    @(posedge i_clock) power_on <= 1'b1;
    @(posedge i_clock);
    wait_ctl(7, 1'b1);
    init_len = 16'(wait_n);
    note(4'h7, 16'(proc_ctrl_pkg::INIT_CYCLES + 4));
    note(4'h6, 16'h0082);
    wait_ctl(3, 1'b1);
    note(4'h6, 16'h00ca);
    alu(4'h5, 1'b0, 16'h5a5a, 16'h5a5a);
    repeat (24) begin
      r = rnd();
      alu(4'h1 + 4'(r[2:0] % 3'h5), r[3], rnd(), rnd());
    end
    for (int k = 0; k < 12; k++) begin
      r = rnd();
      stat(k % 3, r[7:0]);
    end
    for (int k = 0; k < 8; k++) begin
      reg_op(3'(k), 1'b0, rnd(), 1'b0);
      r = rnd();
      reg_op(3'(k), 1'b1, r, k < 6 && r[0]);
    end
    note(4'h3, regs[6]);
    note(4'h4, regs[7]);
    for (int k = 0; k < 2; k++) begin
      @(posedge i_clock) i_halt_switch <= 1'b1;
      wait_ctl(5, 1'b1);
      note(4'h6, 16'h00b2);
      if (k == 0) begin
        @(posedge i_clock) i_resume <= 1'b1;
        @(posedge i_clock) i_resume <= 1'b0;
        note(4'h8, 16'h0002);
        @(posedge i_clock) i_step_done <= 1'b1;
        @(posedge i_clock) i_step_done <= 1'b0;
        note(4'h8, 16'h0001);
      end
      @(posedge i_clock) i_halt_switch <= 1'b0;
      r = rnd();
      repeat (4) @(posedge i_clock);
      i_restart <= (k == 0);
      i_resume <= (k == 1);
      i_restart_addr <= r;
      @(posedge i_clock);
      i_restart <= 1'b0;
      i_resume <= 1'b0;
      note(4'h8, 16'h0002);
      if (k == 0)
        note(4'h4, r);
    end
    @(posedge i_clock) power_on <= 1'b0;
    wait_ctl(2, 1'b1);
    note(4'h6, 16'h00c6);
    wait_ctl(7, 1'b0);
    note(4'h8, 16'h0000);
    note(4'h1, 16'h0000);
    repeat (2) @(posedge i_clock);
    end_of_test();
  end
endmodule // testbench
